/* File: logic/adc_seq_pkg.sv */
`default_nettype none
package adc_seq_pkg;
    // Clock rate and derived counts
    localparam int unsigned REF_CLK_HZ       = 20000000;
    localparam int unsigned ISCK_FREQ_HZ     = 19200;
    localparam int unsigned ISCK_HALF_CYC    = REF_CLK_HZ / (2 * ISCK_FREQ_HZ);
    localparam int unsigned EXT_SCK_DIV      = 8;
    localparam int unsigned NOTCH_DIV        = 2560;
    localparam int unsigned CONV_CYC_PER_NOTCH = NOTCH_DIV;
    // Conversion time in milliseconds, one per notch setting
    localparam int unsigned CONV_TIME_60HZ_MS = 133;
    localparam int unsigned CONV_TIME_50HZ_MS = 160;
    localparam int unsigned CONV_CYC_60HZ    = REF_CLK_HZ / 1000 * CONV_TIME_60HZ_MS;
    localparam int unsigned CONV_CYC_50HZ    = REF_CLK_HZ / 1000 * CONV_TIME_50HZ_MS;
    // Notch clock activity: edges within this window mean an external clock
    localparam int unsigned NOTCH_ACT_WIN_US = 400;
    localparam int unsigned NOTCH_ACT_WIN_CYC = REF_CLK_HZ / 1000000 * NOTCH_ACT_WIN_US;
    // Output word layout
    localparam int unsigned WORD_BITS        = 32;
    localparam int unsigned STATUS_BITS      = 3;
    localparam int unsigned RESULT_BITS      = 24;
    localparam int unsigned SUB_LSB_BITS     = 5;
    localparam int unsigned EOC_POS          = 31;
    localparam int unsigned CHAN_POS         = 30;
    localparam int unsigned SIGN_POS         = 29;
    localparam logic        CHAN_RESET       = 1'b0;

    typedef enum logic [1:0] {
        ST_CONVERT = 2'b00,
        ST_SLEEP   = 2'b01,
        ST_OUTPUT  = 2'b11
    } seq_state_e;
endpackage : adc_seq_pkg
`default_nettype wire

/* File: logic/notch_clock_detect.sv */
`timescale 1ns/1ps
`default_nettype none
// Tells a toggling notch clock from a static strap level
module notch_clock_detect
    import adc_seq_pkg::*;
#(
    parameter int unsigned WIN_CYC = NOTCH_ACT_WIN_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic notch_clock_select_pin,
    output logic      ext_clk_mode_q,
    output logic      ext_clk_tick_q,
    output logic      level_high_q
);
    logic [$clog2(WIN_CYC+1)-1:0] idle_q;
    logic                         pin_q;
    logic                         primed_q;
    logic                         rise;

    assign rise = notch_clock_select_pin & ~pin_q & primed_q;

    // First cycle after reset only loads the pin copy, so a strap tied high is not seen as an edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q    <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            pin_q    <= notch_clock_select_pin;
            primed_q <= 1'b1;
        end
    end

    // An edge restarts the window; a full quiet window means a strap level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_q         <= '0;
            ext_clk_mode_q <= 1'b0;
        end else if (primed_q && notch_clock_select_pin != pin_q) begin
            idle_q         <= '0;
            ext_clk_mode_q <= 1'b1;
        end else if (idle_q == ($clog2(WIN_CYC+1))'(WIN_CYC)) begin
            ext_clk_mode_q <= 1'b0;
        end else begin
            idle_q <= idle_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_clk_tick_q <= 1'b0;
            level_high_q   <= 1'b0;
        end else begin
            ext_clk_tick_q <= rise;
            level_high_q   <= notch_clock_select_pin;
        end
    end
endmodule : notch_clock_detect
`default_nettype wire

/* File: logic/adc_serial_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - CS low enables output, wakes device
// - Sleep after conversion while CS high
// - CS rise in output aborts, restarts conversion
// - CS high keeps data output floating
// - Conversion/sleep with CS low shows status
// - Internal mode drives serial clock out
// - External mode: host clocks, device shifts
// - Weak pull-up on in internal mode
// - Clock mode sampled at reset, CS fall
// - Static notch pin picks 60/50 Hz
// - External notch clock: null at f/2560
// - Internal serial clock 19.2 kHz or f/8
// - Transfer is 32 bits
// - Channel 0 at reset, then alternate
// - Order: convert, sleep, output, repeat
// - Sleep holds result unchanged
// - Data changes on falling serial clock
// - Output ends at 32 bits or CS rise
// - Word: status 3, result 24, sub 5
// - CS high before first rise: back to sleep
module adc_serial_sequencer
    import adc_seq_pkg::*;
#(
    parameter int unsigned CONV_60 = CONV_CYC_60HZ,
    parameter int unsigned CONV_50 = CONV_CYC_50HZ,
    parameter int unsigned ACT_WIN = NOTCH_ACT_WIN_CYC
) (
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire logic                   cs_n,
    input  wire logic                   sck_in,
    output logic                        sck_out,
    output logic                        sck_oe_n,
    output logic                        sck_pullup_en,
    output logic                        sdo_out,
    output logic                        sdo_oe_n,
    input  wire logic                   notch_clock_select_pin,
    input  wire logic [RESULT_BITS-1:0] conv_result,
    input  wire logic [SUB_LSB_BITS-1:0] conv_sub_lsb,
    input  wire logic                   result_sign_bit,
    output logic                        channel_indicator_bit,
    output logic                        conv_busy,
    output logic                        notch_50hz,
    output logic                        ext_notch_clk
);
    localparam int CW = 32;

    logic                 rst_q1;
    logic                 rst_q2;
    seq_state_e           state_q;
    logic [CW-1:0]        conv_cnt_q;
    logic [CW-1:0]        conv_len;
    logic [WORD_BITS-1:0] shreg_q;
    logic [5:0]           bit_cnt_q;
    logic                 first_rise_q;
    logic                 cs_q;
    logic                 ext_sck_mode_q;
    logic                 sck_in_q;
    logic                 isck_q;
    logic [CW-1:0]        div_q;
    logic                 ext_mode;
    logic                 ext_tick;
    logic                 notch_high;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 cs_fall;
    logic                 cs_rise;
    logic                 isck_tick;
    logic                 done_conv;
    logic                 word_done;

    // Two-flop reset release
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end

    notch_clock_detect #(.WIN_CYC(ACT_WIN)) u_detect (
        .ref_clk                (ref_clk),
        .rst_n                  (rst_q2),
        .notch_clock_select_pin (notch_clock_select_pin),
        .ext_clk_mode_q         (ext_mode),
        .ext_clk_tick_q         (ext_tick),
        .level_high_q           (notch_high)
    );

    assign cs_fall = cs_q & ~cs_n;
    assign cs_rise = ~cs_q & cs_n;

    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            cs_q <= 1'b1;
        end else begin
            cs_q <= cs_n;
        end
    end

    // Previous clock pin level, for edge detection in external mode
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            sck_in_q <= 1'b1;
        end else begin
            sck_in_q <= sck_in;
        end
    end

    // Mode caught just after reset release and at each CS fall
    logic mode_init_q;
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            mode_init_q    <= 1'b0;
            ext_sck_mode_q <= 1'b0;
        end else begin
            mode_init_q <= 1'b1;
            if (!mode_init_q || cs_fall) begin
                ext_sck_mode_q <= ~sck_in;
            end
        end
    end

    // Conversion length: static pin picks the notch, a clock counts its own edges
    always_comb begin
        if (ext_mode) begin
            conv_len = CW'(CONV_CYC_PER_NOTCH);
        end else if (notch_high) begin
            conv_len = CW'(CONV_50);
        end else begin
            conv_len = CW'(CONV_60);
        end
    end
    assign done_conv = (state_q == ST_CONVERT) && (conv_cnt_q >= conv_len - 1);

    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            conv_cnt_q <= '0;
        end else if (state_q != ST_CONVERT || done_conv) begin
            conv_cnt_q <= '0;
        end else if (!ext_mode || ext_tick) begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
        end
    end

    // Internal serial clock: fixed half period, or eight notch clocks per period
    assign isck_tick = ext_mode ? (ext_tick && div_q >= CW'(EXT_SCK_DIV / 2 - 1))
                                : (div_q >= CW'(ISCK_HALF_CYC - 1));
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            div_q  <= '0;
            isck_q <= 1'b0;
        end else if (state_q != ST_OUTPUT || ext_sck_mode_q) begin
            div_q  <= '0;
            isck_q <= 1'b0;
        end else if (isck_tick) begin
            div_q  <= '0;
            isck_q <= ~isck_q;
        end else if (!ext_mode || ext_tick) begin
            div_q <= div_q + 1'b1;
        end
    end

    assign sck_rise = ext_sck_mode_q ? (sck_in & ~sck_in_q) : (isck_tick & ~isck_q);
    assign sck_fall = ext_sck_mode_q ? (~sck_in & sck_in_q) : (isck_tick & isck_q);

    // Word ends on the fall that follows the last rising edge
    assign word_done = sck_fall && bit_cnt_q == 6'(WORD_BITS);

    // Sequencer
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            state_q <= ST_CONVERT;
        end else begin
            unique case (state_q)
                ST_CONVERT: begin
                    if (done_conv) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (!cs_n) begin
                        state_q <= ST_OUTPUT;
                    end
                end
                ST_OUTPUT: begin
                    if (cs_n && !first_rise_q) begin
                        state_q <= ST_SLEEP;
                    end else if (cs_rise || cs_n) begin
                        state_q <= ST_CONVERT;
                    end else if (word_done) begin
                        state_q <= ST_CONVERT;
                    end
                end
            endcase
        end
    end

    // Rising edges counted in the output phase; the first one commits the transfer
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            bit_cnt_q    <= '0;
            first_rise_q <= 1'b0;
        end else if (done_conv) begin
            bit_cnt_q    <= '0;
            first_rise_q <= 1'b0;
        end else if (state_q == ST_OUTPUT && sck_rise) begin
            first_rise_q <= 1'b1;
            bit_cnt_q    <= bit_cnt_q + 1'b1;
        end
    end

    // Result word: loaded once at end of conversion, static while asleep
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            shreg_q <= '0;
        end else if (done_conv) begin
            shreg_q <= {1'b0, channel_indicator_bit, result_sign_bit,
                        conv_result, conv_sub_lsb};
        end else if (state_q == ST_OUTPUT && sck_fall && first_rise_q) begin
            shreg_q <= {shreg_q[WORD_BITS-2:0], 1'b1};
        end
    end

    // Channel alternates once per finished conversion
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            channel_indicator_bit <= CHAN_RESET;
        end else if (done_conv) begin
            channel_indicator_bit <= ~channel_indicator_bit;
        end
    end

    // Data pin: status outside the output phase, word bit while shifting
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            sdo_out  <= 1'b1;
            sdo_oe_n <= 1'b1;
        end else begin
            sdo_oe_n <= cs_n;
            if (state_q == ST_OUTPUT) begin
                sdo_out <= shreg_q[EOC_POS];
            end else begin
                sdo_out <= (state_q == ST_CONVERT) && !done_conv;
            end
        end
    end

    // Clock pin is driven only while shifting in internal mode
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            sck_out  <= 1'b0;
            sck_oe_n <= 1'b1;
        end else begin
            sck_out  <= isck_q;
            sck_oe_n <= !(state_q == ST_OUTPUT && !ext_sck_mode_q && !cs_n);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            sck_pullup_en <= 1'b1;
        end else begin
            sck_pullup_en <= !ext_sck_mode_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            conv_busy <= 1'b1;
        end else begin
            conv_busy <= (state_q == ST_CONVERT) && !done_conv;
        end
    end

    // Clock source status
    always_ff @(posedge ref_clk or negedge rst_q2) begin
        if (!rst_q2) begin
            notch_50hz    <= 1'b0;
            ext_notch_clk <= 1'b0;
        end else begin
            notch_50hz    <= notch_high && !ext_mode;
            ext_notch_clk <= ext_mode;
        end
    end
endmodule : adc_serial_sequencer
`default_nettype wire

/* File: testbench/adc_seq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_properties
    import adc_seq_pkg::*;
(
    input wire logic                    ref_clk,
    input wire logic                    reset_n,
    input wire logic                    cs_n,
    input wire logic                    sck_in,
    input wire logic                    sck_out,
    input wire logic                    sck_oe_n,
    input wire logic                    sck_pullup_en,
    input wire logic                    sdo_out,
    input wire logic                    sdo_oe_n,
    input wire logic                    notch_clock_select_pin,
    input wire logic [RESULT_BITS-1:0]  conv_result,
    input wire logic [SUB_LSB_BITS-1:0] conv_sub_lsb,
    input wire logic                    result_sign_bit,
    input wire logic                    channel_indicator_bit,
    input wire logic                    conv_busy,
    input wire logic                    notch_50hz,
    input wire logic                    ext_notch_clk
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_cs_high_float: assert property (cs_n |=> sdo_oe_n) else $error("sdo driven while deselected");
    a_cs_low_drive: assert property (!cs_n && $past(reset_n, 3) |=> !sdo_oe_n)
        else $error("sdo not driven after select");
    a_status_busy: assert property (conv_busy && $past(conv_busy) && !sdo_oe_n |-> sdo_out)
        else $error("status bit low while converting");
    a_pullup_int: assert property (!sck_oe_n |-> sck_pullup_en) else $error("sck driven without pull-up");
    a_sck_release: assert property (cs_n ##1 cs_n |-> sck_oe_n) else $error("sck driven while deselected");
    a_sleep_hold: assert property ((cs_n && !conv_busy)[*3] |=> !conv_busy)
        else $error("sleep left while deselected");
    a_chan_toggle: assert property ($fell(conv_busy) |-> $changed(channel_indicator_bit))
        else $error("channel did not alternate");
    a_shift_fall: assert property (!sdo_oe_n && !conv_busy && !$past(conv_busy) && $changed(sdo_out)
        |-> !sck_in) else $error("sdo changed outside a low clock phase");
endmodule : adc_seq_properties
`default_nettype wire

/* File: testbench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic ref_clk,
    input  wire logic sdo_out,
    input  wire logic sdo_oe_n,
    input  wire logic sck_lvl,
    output logic      cs_n,
    output logic      sck_drv,
    output logic      sck_en
);
    logic sdo_last;
    logic sdo_line;
    always_ff @(posedge ref_clk) begin
        if (!sdo_oe_n) begin
            sdo_last <= sdo_out;
        end
    end
    // Released line shows a flipped level so a stale bit cannot pass
    assign sdo_line = sdo_oe_n ? ~sdo_last : sdo_out;
    initial begin
        cs_n = 1'b1;
        sck_drv = 1'b0;
        sck_en = 1'b1;
    end
    task automatic xfer(input int n, input logic ext, output logic [31:0] w);
        int t;
        w = '0;
        @(posedge ref_clk);
        // Mode strap: low asks for a host clock, high for the device clock
        sck_en <= 1'b1;
        sck_drv <= ~ext;
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b0;
        // Hold the strap over the select edge, then leave the pin to the device in internal mode; in external mode the host keeps driving it
        @(posedge ref_clk);
        sck_en <= ext;
        repeat (5) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            if (ext) begin
                w[31-i] = sdo_line;
                sck_drv <= 1'b1;
                repeat (6) @(posedge ref_clk);
                sck_drv <= 1'b0;
                repeat (6) @(posedge ref_clk);
            end else begin
                for (t = 0; t < 2000 && sck_lvl !== 1'b0; t++) @(posedge ref_clk);
                for (t = 0; t < 2000 && sck_lvl !== 1'b1; t++) @(posedge ref_clk);
                w[31-i] = sdo_line;
            end
        end
        // Let the device finish the last high phase and its closing fall on its own clock
        if (!ext) repeat (600) @(posedge ref_clk);
        cs_n <= 1'b1;
        sck_en <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask : xfer
endmodule : host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import adc_seq_pkg::*;
;
    logic                    ref_clk, reset_n, cs_n, sck_lvl, sck_out, sck_oe_n, sck_pullup_en;
    logic                    sdo_out, sdo_oe_n, notch, sign, chan, conv_busy, notch_50hz, ext_notch_clk;
    logic                    sck_drv, sck_en;
    logic [RESULT_BITS-1:0]  res;
    logic [SUB_LSB_BITS-1:0] sub;
    logic [31:0]             w, exp;
    int                      err_total, n_tests;
    realtime                 t0;
    assign sck_lvl = !sck_oe_n ? sck_out : (sck_en ? sck_drv : sck_pullup_en);
    adc_serial_sequencer #(.CONV_60(200), .CONV_50(200), .ACT_WIN(20)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n), .sck_in(sck_lvl), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
        .notch_clock_select_pin(notch), .conv_result(res), .conv_sub_lsb(sub), .result_sign_bit(sign),
        .channel_indicator_bit(chan), .conv_busy(conv_busy), .notch_50hz(notch_50hz),
        .ext_notch_clk(ext_notch_clk));
    host_model host (.ref_clk(ref_clk), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .sck_lvl(sck_lvl),
        .cs_n(cs_n), .sck_drv(sck_drv), .sck_en(sck_en));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task automatic wait_idle();
        for (int t = 0; t < 3000 && conv_busy !== 1'b0; t++) @(posedge ref_clk);
        repeat (20) @(posedge ref_clk);
    endtask : wait_idle
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        results();
    end
    initial begin
        reset_n = 1'b0;
        notch = 1'b0;
        res = 24'hA5C396;
        sub = 5'h15;
        sign = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check({sdo_oe_n, chan, notch_50hz}, 32'h4);
        fork
            host.xfer(0, 1'b1, w);
            begin
                repeat (9) @(negedge ref_clk);
                check({conv_busy, sdo_oe_n, sdo_out}, 32'h5);
            end
        join
        $display("test status done");
        wait_idle();
        exp = {1'b0, 1'b0, sign, res, sub};
        res <= 24'h5A3C69;
        sub <= 5'h0A;
        sign <= 1'b0;
        repeat (50) @(posedge ref_clk);
        host.xfer(32, 1'b1, w);
        check(w, exp);
        $display("test full word done");
        wait_idle();
        exp = {1'b0, 1'b1, sign, res, sub};
        host.xfer(0, 1'b1, w);
        repeat (20) @(posedge ref_clk);
        check(conv_busy, 1'b0);
        res <= 24'h000001;
        sub <= 5'h1F;
        sign <= 1'b1;
        host.xfer(32, 1'b1, w);
        check(w, exp);
        $display("test early release done");
        wait_idle();
        exp = {1'b0, 1'b0, sign, res, sub};
        host.xfer(5, 1'b1, w);
        check(w[31:27], exp[31:27]);
        check(conv_busy, 1'b1);
        $display("test abort done");
        wait_idle();
        exp = {1'b0, 1'b1, sign, res, sub};
        fork
            host.xfer(32, 1'b0, w);
            begin
                @(posedge sck_out);
                t0 = $realtime;
                check({sck_pullup_en, sck_oe_n}, 32'h2);
                @(posedge sck_out);
                check(32'(int'(($realtime - t0) / 50.0)), 32'(2 * ISCK_HALF_CYC));
            end
        join
        check(w, exp);
        $display("test internal clock done");
        notch <= 1'b1;
        repeat (50) @(posedge ref_clk);
        check({notch_50hz, ext_notch_clk}, 32'h2);
        // Five cycles per level keeps the notch clock at 2 MHz
        repeat (40) begin
            repeat (5) @(posedge ref_clk);
            notch <= ~notch;
        end
        check(ext_notch_clk, 1'b1);
        $display("test notch select done");
        results();
    end
endmodule : tb_top
bind adc_serial_sequencer adc_seq_properties chk (.ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sck_pullup_en(sck_pullup_en),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .notch_clock_select_pin(notch_clock_select_pin),
    .conv_result(conv_result), .conv_sub_lsb(conv_sub_lsb), .result_sign_bit(result_sign_bit),
    .channel_indicator_bit(channel_indicator_bit), .conv_busy(conv_busy), .notch_50hz(notch_50hz),
    .ext_notch_clk(ext_notch_clk));
`default_nettype wire
